// ---- pkg/led_pwm_pkg.sv ----
// constants, register map and state layout for the led pwm output control block
package led_pwm_pkg;

  // register offsets as seen by the serial engine
  localparam logic [7:0] ADDR_PORT_INPUT_LEVELS = 8'h00;
  localparam logic [7:0] ADDR_PHASE0_OUTPUT_PATTERN = 8'h01;
  localparam logic [7:0] ADDR_PORT_DIRECTION = 8'h03;
  localparam logic [7:0] ADDR_PHASE1_OUTPUT_PATTERN = 8'h09;
  localparam logic [7:0] ADDR_MASTER_NINTH_INTENSITY = 8'h0E;
  localparam logic [7:0] ADDR_CONFIGURATION = 8'h0F;
  localparam logic [7:0] ADDR_OUTPUT_INTENSITY_BASE = 8'h10;
  localparam logic [7:0] ADDR_OUTPUT_INTENSITY_LAST = 8'h13;

  // configuration register field positions
  localparam int CFG_BLINK_ENABLE = 0;
  localparam int CFG_BLINK_FLIP = 1;
  localparam int CFG_GLOBAL_INTENSITY = 2;
  localparam int CFG_IRQ_ENABLE = 3;
  localparam int CFG_NINTH_PHASE0 = 4;
  localparam int CFG_NINTH_PHASE1 = 5;
  localparam logic [7:0] CFG_READ_MASK = 8'h3F;

  // values after reset
  localparam logic [7:0] RESET_PHASE_PATTERN = 8'hFF;
  localparam logic [7:0] RESET_PORT_DIRECTION = 8'hFF;
  localparam logic [7:0] RESET_MASTER_NINTH = 8'h00;
  localparam logic [7:0] RESET_CONFIGURATION = 8'h00;
  localparam logic [7:0] RESET_OUTPUT_INTENSITY = 8'hFF;

  // pwm timing
  localparam int CLK_HZ = 25000000;
  localparam int OSC_HZ = 32000;
  localparam int OSC_DIV = CLK_HZ / OSC_HZ;
  localparam logic [9:0] OSC_DIV_LAST = 10'(OSC_DIV - 1);
  localparam logic [3:0] SLOT_LAST = 4'hE;
  localparam logic [3:0] CYCLE_LAST = 4'hF;
  localparam logic [3:0] INTENSITY_STATIC = 4'hF;
  localparam logic [3:0] MASTER_OFF = 4'h0;

  // request from the serial protocol engine
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_type;

  typedef struct packed {
    logic [7:0] phase0;
    logic [7:0] phase1;
    logic [7:0] port_dir;
    logic [7:0] master_ninth;
    logic [7:0] config_bits;
    logic [3:0][7:0] intensity;
    logic [7:0] sync1;
    logic [7:0] sync2;
    logic [7:0] sync3;
    logic [7:0] pin_levels;
    logic [9:0] osc_div;
    logic [3:0] cycle;
    logic [3:0] slot;
    logic [7:0] port_oe;
    logic ninth_oe;
    logic [8:0] drive_level;
    logic [7:0] rdata;
  } state_type;

  localparam state_type RESET_STATE = '{
    phase0: RESET_PHASE_PATTERN,
    phase1: RESET_PHASE_PATTERN,
    port_dir: RESET_PORT_DIRECTION,
    master_ninth: RESET_MASTER_NINTH,
    config_bits: RESET_CONFIGURATION,
    intensity: {4{RESET_OUTPUT_INTENSITY}},
    sync1: 8'h00,
    sync2: 8'h00,
    sync3: 8'h00,
    pin_levels: 8'h00,
    osc_div: 10'h000,
    cycle: 4'h0,
    slot: 4'h0,
    port_oe: 8'h00,
    ninth_oe: 1'b0,
    drive_level: 9'h000,
    rdata: 8'h00
  };

endpackage

// ---- src/led_pwm_blink_output_control.sv ----
// blink pattern, ninth output and pwm intensity logic of an eight-port expander
//
// Operation
// - pattern register reads return stored bits, not pin levels
// - ninth output follows two config bits, one per blink phase
// - pwm steps come from a nominal 32 kHz enable divided from clk
// - master off makes outputs static and stops the oscillator divider
// - each port has its own four-bit intensity nibble
// - pwm period is 15 timeslots of 16 cycles, 240 steps
// - master value enables 1 to 15 timeslots per period
// - intensity gives duty 1/16 to 15/16 inside enabled slots only
// - intensity 16/16 ignores master and holds the active pattern bit
// - blink disabled: on-time level comes from phase 0 pattern
// - bit 0 gives on-duty 1/16..full; bit 1 gives off..15/16
// - blink enable selects phase by flip flag, else phase 0
// - global flag uses ninth output nibble as common intensity
// - global intensity applies to every output-configured port
// - master nibble zero disables pwm regardless of other settings
// - pattern bit 1 releases pin, bit 0 pulls it low
// - global intensity taken from low nibble of master register
// - without global, ports use the four per-output intensity registers
`timescale 1ns/1ns
`default_nettype none

module led_pwm_blink_output_control (
  input wire logic clk,
  input wire logic rst,
  input wire led_pwm_pkg::reg_req_type reg_req,
  output logic [7:0] reg_rdata,
  input wire logic [7:0] port_pins_in,
  output logic [7:0] port_pins_out,
  output logic [7:0] port_pins_oe,
  output logic ninth_output_out,
  output logic ninth_output_oe
);

  led_pwm_pkg::state_type s;
  led_pwm_pkg::state_type next_s;

  // level seen on a pin: 1 released, 0 pulled low
  function automatic logic pin_level(
    input logic pattern_bit,
    input logic [3:0] inten,
    input logic [3:0] master,
    input logic [3:0] slot,
    input logic [3:0] cycle
  );
    logic on_time;
    on_time = (slot < master) && (cycle <= inten);
    if (master == led_pwm_pkg::MASTER_OFF) begin
      pin_level = pattern_bit;
    end else if (inten == led_pwm_pkg::INTENSITY_STATIC) begin
      pin_level = pattern_bit;
    end else begin
      pin_level = on_time ? pattern_bit : ~pattern_bit;
    end
  endfunction

  // the four per-port intensity registers form one contiguous window
  function automatic logic is_intensity_addr(input logic [7:0] addr);
    is_intensity_addr = (addr >= led_pwm_pkg::ADDR_OUTPUT_INTENSITY_BASE) &&
                        (addr <= led_pwm_pkg::ADDR_OUTPUT_INTENSITY_LAST);
  endfunction

  always_comb begin
    logic blink_sel;
    logic osc_run;
    logic [3:0] master;
    logic [3:0] inten;
    logic pattern_bit;
    logic level;
    logic [1:0] pair;
    next_s = s;
    blink_sel = 1'b0;
    osc_run = 1'b0;
    master = s.master_ninth[7:4];
    inten = 4'h0;
    pattern_bit = 1'b0;
    level = 1'b0;
    pair = 2'b00;

    // pins cross in through three flops; a change counts when the last two agree
    next_s.sync1 = port_pins_in;
    next_s.sync2 = s.sync1;
    next_s.sync3 = s.sync2;
    if (s.sync2 == s.sync3) begin
      next_s.pin_levels = s.sync3;
    end

    if (reg_req.wr) begin
      unique case (reg_req.addr)
        led_pwm_pkg::ADDR_PHASE0_OUTPUT_PATTERN: next_s.phase0 = reg_req.wdata;
        led_pwm_pkg::ADDR_PORT_DIRECTION: next_s.port_dir = reg_req.wdata;
        led_pwm_pkg::ADDR_PHASE1_OUTPUT_PATTERN: next_s.phase1 = reg_req.wdata;
        led_pwm_pkg::ADDR_MASTER_NINTH_INTENSITY: next_s.master_ninth = reg_req.wdata;
        led_pwm_pkg::ADDR_CONFIGURATION: next_s.config_bits = reg_req.wdata;
        default: begin
          if (is_intensity_addr(reg_req.addr)) begin
            pair = reg_req.addr[1:0];
            next_s.intensity[pair] = reg_req.wdata;
          end
        end
      endcase
    end

    if (reg_req.rd) begin
      unique case (reg_req.addr)
        led_pwm_pkg::ADDR_PORT_INPUT_LEVELS: next_s.rdata = s.pin_levels;
        led_pwm_pkg::ADDR_PHASE0_OUTPUT_PATTERN: next_s.rdata = s.phase0;
        led_pwm_pkg::ADDR_PORT_DIRECTION: next_s.rdata = s.port_dir;
        led_pwm_pkg::ADDR_PHASE1_OUTPUT_PATTERN: next_s.rdata = s.phase1;
        led_pwm_pkg::ADDR_MASTER_NINTH_INTENSITY: next_s.rdata = s.master_ninth;
        // interrupt status lives in the serial/interrupt logic, so reads zero here
        led_pwm_pkg::ADDR_CONFIGURATION: begin
          next_s.rdata = s.config_bits & led_pwm_pkg::CFG_READ_MASK;
        end
        default: begin
          if (is_intensity_addr(reg_req.addr)) begin
            pair = reg_req.addr[1:0];
            next_s.rdata = s.intensity[pair];
          end else begin
            next_s.rdata = 8'h00;
          end
        end
      endcase
    end

    // divider, cycle and slot cleared to zero while pwm is off
    osc_run = (master != led_pwm_pkg::MASTER_OFF);
    if (!osc_run) begin
      next_s.osc_div = 10'h000;
      next_s.cycle = 4'h0;
      next_s.slot = 4'h0;
    end else if (s.osc_div == led_pwm_pkg::OSC_DIV_LAST) begin
      next_s.osc_div = 10'h000;
      // 16 cycles per slot, 15 slots
      next_s.cycle = s.cycle + 4'h1;
      if (s.cycle == led_pwm_pkg::CYCLE_LAST) begin
        next_s.slot = (s.slot == led_pwm_pkg::SLOT_LAST) ? 4'h0 : s.slot + 4'h1;
      end
    end else begin
      next_s.osc_div = s.osc_div + 10'h001;
    end

    blink_sel = s.config_bits[led_pwm_pkg::CFG_BLINK_ENABLE] &
                s.config_bits[led_pwm_pkg::CFG_BLINK_FLIP];

    for (int i = 0; i < 8; i++) begin
      // phase 0 unless blinking in phase 1
      pattern_bit = blink_sel ? s.phase1[i] : s.phase0[i];
      if (s.config_bits[led_pwm_pkg::CFG_GLOBAL_INTENSITY]) begin
        inten = s.master_ninth[3:0];
      end else begin
        // even port low nibble, odd port high nibble
        inten = i[0] ? s.intensity[i / 2][7:4] : s.intensity[i / 2][3:0];
      end
      level = pin_level(pattern_bit, inten, master, s.slot, s.cycle);
      next_s.drive_level[i] = level;
      // only ports configured as outputs drive
      // open drain pulls low only for level 0
      next_s.port_oe[i] = ~s.port_dir[i] & ~level;
    end

    // ninth output from its two phase bits
    pattern_bit = blink_sel ? s.config_bits[led_pwm_pkg::CFG_NINTH_PHASE1] :
                              s.config_bits[led_pwm_pkg::CFG_NINTH_PHASE0];
    level = pin_level(pattern_bit, s.master_ninth[3:0], master, s.slot, s.cycle);
    next_s.drive_level[8] = level;
    // while the pin serves as interrupt, that logic owns it; release here
    next_s.ninth_oe = ~s.config_bits[led_pwm_pkg::CFG_IRQ_ENABLE] & ~level;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s <= led_pwm_pkg::RESET_STATE;
    end else begin
      s <= next_s;
    end
  end

  // open-drain pins only ever drive low; the enables carry the pattern
  assign reg_rdata = s.rdata;
  assign port_pins_oe = s.port_oe;
  assign port_pins_out = 8'h00;
  assign ninth_output_oe = s.ninth_oe;
  assign ninth_output_out = 1'b0;

endmodule

`default_nettype wire

// ---- test/led_pwm_monitor.sv ----
// assertion checker for the led pwm output control ports
`timescale 1ns/1ns
`default_nettype none
module led_pwm_monitor (
  input wire logic clk,
  input wire logic rst,
  input wire led_pwm_pkg::reg_req_type reg_req,
  input wire logic [7:0] reg_rdata,
  input wire logic [7:0] port_pins_in,
  input wire logic [7:0] port_pins_out,
  input wire logic [7:0] port_pins_oe,
  input wire logic ninth_output_out,
  input wire logic ninth_output_oe
);
  logic [7:0] mi;
  logic [7:0] dir;
  logic glob;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // shadow copies of the registers that decide static versus pwm and which ports may drive
  always_ff @(posedge clk) begin
    if (rst) begin
      mi <= 8'h00;
      dir <= 8'hFF;
      glob <= 1'b0;
    end else if (reg_req.wr && reg_req.addr == 8'h0E) begin
      mi <= reg_req.wdata;
    end else if (reg_req.wr && reg_req.addr == 8'h03) begin
      dir <= reg_req.wdata;
    end else if (reg_req.wr && reg_req.addr == 8'h0F) begin
      glob <= reg_req.wdata[2];
    end
  end
  out_low_a: assert property (port_pins_out == 8'h00) else $error("pin out not zero");
  ninth_low_a: assert property (!ninth_output_out) else $error("ninth out not zero");
  readback_a: assert property (reg_req.wr && reg_req.addr == 8'h01 ##1
    reg_req.rd && !reg_req.wr && reg_req.addr == 8'h01
    |=> reg_rdata == $past(reg_req.wdata, 2)) else $error("phase read not stored value");
  pin_level_a: assert property ($stable(port_pins_in)[*7] ##0
    reg_req.rd && reg_req.addr == 8'h00 |=> reg_rdata == $past(port_pins_in))
    else $error("input register not pin level");
  rdata_hold_a: assert property (!reg_req.rd |=> $stable(reg_rdata)) else $error("rdata moved");
  static_off_a: assert property ((!reg_req.wr && mi[7:4] == 4'h0)[*3]
    |=> $stable(port_pins_oe)) else $error("pwm with master off");
  static_full_a: assert property ((!reg_req.wr && glob && mi[3:0] == 4'hF)[*3]
    |=> $stable(port_pins_oe)) else $error("pwm with full intensity");
  input_quiet_a: assert property ((!reg_req.wr)[*3]
    |-> (port_pins_oe & dir) == 8'h00) else $error("input port driven");
  cover property (reg_req.wr && reg_req.addr == 8'h0F);
  cover property (reg_req.rd && reg_req.addr == 8'h00);
  cover property ($rose(ninth_output_oe));
endmodule
bind led_pwm_blink_output_control led_pwm_monitor i_mon (.clk(clk), .rst(rst),
  .reg_req(reg_req), .reg_rdata(reg_rdata), .port_pins_in(port_pins_in),
  .port_pins_out(port_pins_out), .port_pins_oe(port_pins_oe),
  .ninth_output_out(ninth_output_out), .ninth_output_oe(ninth_output_oe));
`default_nettype wire

// ---- test/led_pwm_host.sv ----
// host model issuing register requests one per cycle
`timescale 1ns/1ns
`default_nettype none
module led_pwm_host (
  input wire logic clk,
  output var led_pwm_pkg::reg_req_type reg_req
);
  initial reg_req = '0;
  // whole request changes in one assignment, so back to back calls never clash
  task automatic xfer(input logic [7:0] a, input logic [7:0] d, input logic w, input logic r);
    @(posedge clk);
    #1 reg_req = '{addr: a, wdata: d, wr: w, rd: r};
  endtask
endmodule
`default_nettype wire

// ---- test/led_pwm_blink_output_control_bench.sv ----
// testbench for the led pwm output control block
`timescale 1ns/1ns
`default_nettype none
module led_pwm_blink_output_control_bench;
  logic clk, rst, n_out, n_oe, pend;
  led_pwm_pkg::reg_req_type reg_req;
  logic [7:0] reg_rdata, pins_in, pins_out, pins_oe, v;
  logic [7:0] exp_q[$];
  int err_count, n_compared;
  led_pwm_blink_output_control i_dut (.clk(clk), .rst(rst), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .port_pins_in(pins_in), .port_pins_out(pins_out),
    .port_pins_oe(pins_oe), .ninth_output_out(n_out), .ninth_output_oe(n_oe));
  led_pwm_host i_host (.clk(clk), .reg_req(reg_req));
  task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    i_host.xfer(a, 8'h00, 1'b0, 1'b1);
  endtask
  // outputs lag a write by two edges; four idle cycles leave margin
  task automatic put(input logic [7:0] a, input logic [7:0] d, input logic [8:0] e);
    i_host.xfer(a, d, 1'b1, 1'b0);
    repeat (4) i_host.xfer(8'h00, 8'h00, 1'b0, 1'b0);
    check("oe", {n_oe, pins_oe}, e);
  endtask
  always @(posedge clk) begin
    #2;
    if (pend) check("rdata", {1'b0, reg_rdata}, {1'b0, exp_q.pop_front()});
    pend = reg_req.rd;
  end
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    // pwm sweep needs 17 steps of 781 clocks on top of the register tests
    #1000000;
    err_count++;
    end_of_test();
  end
  initial begin
    err_count = 0;
    n_compared = 0;
    pend = 1'b0;
    rst = 1'b1;
    v = 8'($urandom(41412));
    v = 8'($urandom());
    pins_in = ~v;
    repeat (4) @(posedge clk);
    #1 rst = 1'b0;
    rd(8'h01, 8'hFF);
    rd(8'h09, 8'hFF);
    i_host.xfer(8'h01, v, 1'b1, 1'b0);
    rd(8'h01, v);
    i_host.xfer(8'h00, v, 1'b1, 1'b0);
    rd(8'h00, ~v);
    put(8'h03, 8'h00, {1'b1, ~v});
    put(8'h0F, 8'h10, {1'b0, ~v});
    put(8'h0F, 8'h03, {1'b1, 8'h00});
    put(8'h09, 8'h0F, {1'b1, 8'hF0});
    put(8'h0F, 8'h21, {1'b1, ~v});
    put(8'h0F, 8'h23, {1'b0, 8'hF0});
    put(8'h0F, 8'h04, {1'b1, ~v});
    put(8'h0E, 8'hFF, {1'b1, ~v});
    repeat (2000) i_host.xfer(8'h00, 8'h00, 1'b0, 1'b0);
    check("static", {n_oe, pins_oe}, {1'b1, ~v});
    // stop the divider, then one master slot with port 0 at 1/16 and port 1 at 4/16
    i_host.xfer(8'h0E, 8'h00, 1'b1, 1'b0);
    i_host.xfer(8'h0F, 8'h00, 1'b1, 1'b0);
    i_host.xfer(8'h01, 8'h00, 1'b1, 1'b0);
    i_host.xfer(8'h10, 8'h30, 1'b1, 1'b0);
    i_host.xfer(8'h0E, 8'h1F, 1'b1, 1'b0);
    i_host.xfer(8'h00, 8'h00, 1'b0, 1'b0);
    // sample in the middle of each 781-clock step; step 16 falls in the gated-off slot
    repeat (390) @(posedge clk);
    for (int c = 0; c < 17; c++) begin
      #2;
      check("pwm", {n_oe, pins_oe}, {1'b1, 6'h3F, (c <= 3), (c == 0)});
      repeat (781) @(posedge clk);
    end
    end_of_test();
  end
endmodule
`default_nettype wire
